// >>> core/gpib_status_core.sv
// Status byte, event registers, enable masks and service request for a GPIB instrument.
// Assumes commands arrive pre-parsed on ref_clk_in; condition inputs may be asynchronous.
//
// Behaviour
// - Bit 6 of the service request mask ignores writes and reads zero.
// - Error queue summary is true exactly while the error queue is non-empty.
// - Message available is true exactly while the output queue holds unread bytes.
// - Hardware, coupling, instrument summaries each reflect their own masked event register.
// - SRQ line is asserted whenever request-for-service is set.
// - Request-for-service sets only on a new reason for service.
// - Request-for-service clears when master summary falls or on serial poll.
// - Clear-status clears all event registers and empties the error queue.
// - Standard event enable mask is writable and reads back its stored value.
// - Standard event status query returns the standard event register.
// - Service request enable mask is writable and reads back its stored value.
// - Status byte query returns the status byte with master summary in bit 6.
// - Coupling group: condition and event readable, enable mask writable and readable.
// - Hardware group: condition and event readable, enable mask writable and readable.
// - Instrument group: condition and event readable, enable mask writable and readable.
// - Condition queries return the live condition value of each group.
// - Every query answer is an unsigned decimal integer.
// - Master summary is true when status byte AND enable mask is non-zero.
// - Event bits stay set until their register is read or status cleared.
// - Clear-status leaves enable masks alone; power-on zeroes every enable mask.
// - Bit 7 error summary, bits 1 to 3 group summaries, bit 0 unused.
`include "gpib_status_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module gpib_status_core #(
	parameter int          GRP_W         = 16,
	parameter logic [47:0] POS_EDGE_MASK = 48'hFFFF_FFFF_FFFF
) (
	// Clock, reset, enable
	input  wire logic                      ref_clk_in,
	input  wire logic                      rstn_in,
	input  wire logic                      ce_in,
	// Condition pins, asynchronous
	input  wire logic [15:0]               hw_cond_in,
	input  wire logic [15:0]               cpl_cond_in,
	input  wire logic [15:0]               ins_cond_in,
	// Same-clock event and queue state
	input  wire logic [7:0]                std_event_set_in,
	input  wire logic                      err_queue_nonempty_in,
	input  wire logic                      out_queue_nonempty_in,
	// Command port
	input  wire logic                      cmd_valid_in,
	input  wire gpib_status_pkg::cmd_req_t cmd_in,
	input  wire logic                      serial_poll_in,
	// Answers
	output logic                           resp_valid_out,
	output gpib_status_pkg::resp_t         resp_out,
	output logic                           poll_valid_out,
	output logic [7:0]                     poll_byte_out,
	// Status and side effects
	output logic                           srq_out,
	output logic [7:0]                     status_byte_out,
	output logic                           err_queue_flush_out
);

	// ------------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------------
	if (GRP_W < 1 || GRP_W > 16) begin : g_bad_width
		$error("GRP_W must lie between 1 and 16");
	end

	// ------------------------------------------------------------------------
	// Decode functions
	// ------------------------------------------------------------------------
	function automatic logic [4:0] grp_offset(input gpib_status_pkg::cmd_t c);
		return 5'(c - gpib_status_pkg::hardware_condition_query);
	endfunction

	function automatic logic is_grp_cmd(input gpib_status_pkg::cmd_t c);
		return c >= gpib_status_pkg::hardware_condition_query &&
		       c <= gpib_status_pkg::instrument_event_query;
	endfunction

	function automatic logic grp_hit(input gpib_status_pkg::cmd_t c, input int g,
	                                 input logic [1:0] k);
		return is_grp_cmd(c) && grp_offset(c) == 5'(g * 4 + int'(k));
	endfunction

	function automatic logic is_query(input gpib_status_pkg::cmd_t c);
		logic [4:0] o;
		o = grp_offset(c);
		return (is_grp_cmd(c) && o[1:0] != `KIND_EN_WR) ||
		       c == gpib_status_pkg::std_enable_query ||
		       c == gpib_status_pkg::std_event_query ||
		       c == gpib_status_pkg::srq_enable_query ||
		       c == gpib_status_pkg::status_byte_query;
	endfunction

	// Shift-and-add conversion; a 16-bit value needs five digits at most
	function automatic logic [19:0] to_bcd(input logic [15:0] v);
		logic [35:0] s;
		s = {20'h00000, v};
		for (int i = 0; i < 16; i++) begin
			for (int d = 0; d < 5; d++) begin
				if (s[16 + 4 * d +: 4] > 4'h4) begin
					s[16 + 4 * d +: 4] = s[16 + 4 * d +: 4] + 4'h3;
				end
			end
			s = s << 1;
		end
		return s[35:16];
	endfunction

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic [2:0][15:0] cond_meta_reg;
	logic [2:0][15:0] cond_sync_reg;
	logic [2:0][15:0] cond_prev_reg;
	logic [2:0][15:0] event_reg;
	logic [2:0][15:0] event_next;
	logic [2:0][15:0] enable_reg;
	logic [2:0][15:0] enable_next;
	logic [2:0]       grp_summary;
	logic [7:0]       std_event_reg;
	logic [7:0]       std_event_next;
	logic [7:0]       ese_reg;
	logic [7:0]       ese_next;
	logic [7:0]       sre_reg;
	logic [7:0]       sre_next;
	logic [7:0]       reason_prev_reg;
	logic             rqs_reg;
	logic             rqs_next;
	logic             resp_valid_reg;
	gpib_status_pkg::resp_t resp_reg;
	logic             poll_valid_reg;
	logic [7:0]       poll_byte_reg;
	logic [7:0]       stb_reg;
	logic             flush_reg;

	// ------------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------------
	wire              cmd_hit   = cmd_valid_in;
	wire gpib_status_pkg::cmd_t cmd = cmd_in.cmd;
	wire              cls_hit   = cmd_hit && cmd == gpib_status_pkg::clear_status;
	wire              poll_hit  = serial_poll_in;
	wire [2:0][15:0]  cond_raw  = {ins_cond_in, cpl_cond_in, hw_cond_in};
	wire [15:0]       grp_keep  = 16'((17'h00001 << GRP_W) - 17'h00001);

	// ------------------------------------------------------------------------
	// Event groups
	// ------------------------------------------------------------------------
	// Edge polarity per bit is fixed at build time; software cannot retune it
	for (genvar g = 0; g < 3; g++) begin : g_grp
		wire [15:0] pos  = POS_EDGE_MASK[16 * g +: 16];
		wire [15:0] rise = cond_sync_reg[g] & ~cond_prev_reg[g];
		wire [15:0] fall = ~cond_sync_reg[g] & cond_prev_reg[g];
		wire [15:0] set  = ((rise & pos) | (fall & ~pos)) & grp_keep;
		wire        clr  = cls_hit || (cmd_hit && grp_hit(cmd, g, `KIND_EVENT));
		wire        wr   = cmd_hit && grp_hit(cmd, g, `KIND_EN_WR);
		// Set wins over a read or clear-status in the same cycle
		assign event_next[g]  = set | (event_reg[g] & {16{~clr}});
		assign enable_next[g] = wr ? (cmd_in.data & grp_keep) : enable_reg[g];
		assign grp_summary[g] = |(event_reg[g] & enable_reg[g]);
	end

	// ------------------------------------------------------------------------
	// Standard event, masks and status byte
	// ------------------------------------------------------------------------
	wire        ese_wr = cmd_hit && cmd == gpib_status_pkg::std_enable_write;
	wire        sre_wr = cmd_hit && cmd == gpib_status_pkg::srq_enable_write;
	wire        esr_rd = cmd_hit && cmd == gpib_status_pkg::std_event_query;
	wire [7:0]  stb_base;
	wire        mss;
	wire [7:0]  stb_query;
	wire [7:0]  reason;
	wire        new_reason;
	logic [15:0] rd_value;

	assign std_event_next = std_event_set_in | (std_event_reg & {8{~(cls_hit || esr_rd)}});
	assign ese_next       = ese_wr ? cmd_in.data[7:0] : ese_reg;
	assign sre_next       = sre_wr ? (cmd_in.data[7:0] & `SRE_WR_MASK) : sre_reg;

	assign stb_base[`STB_UNUSED_BIT] = 1'b0;
	assign stb_base[`STB_ISB_BIT]    = grp_summary[`GRP_IN];
	assign stb_base[`STB_CSB_BIT]    = grp_summary[`GRP_CP];
	assign stb_base[`STB_HSB_BIT]    = grp_summary[`GRP_HW];
	assign stb_base[`STB_MAV_BIT]    = out_queue_nonempty_in;
	assign stb_base[`STB_ESB_BIT]    = |(std_event_reg & ese_reg);
	assign stb_base[`STB_MSS_BIT]    = 1'b0;
	assign stb_base[`STB_ERB_BIT]    = err_queue_nonempty_in;

	assign mss        = |(stb_base & sre_reg);
	assign stb_query  = stb_base | ({7'h00, mss} << `STB_MSS_BIT);
	assign reason     = stb_base & sre_reg;
	// Only bits that newly join the reason count, so a steady cause polled once stays quiet
	assign new_reason = |(reason & ~reason_prev_reg);
	assign rqs_next   = new_reason ? 1'b1 : ((!mss || poll_hit) ? 1'b0 : rqs_reg);

	// ------------------------------------------------------------------------
	// Query answer selection
	// ------------------------------------------------------------------------
	function automatic logic [15:0] read_mux(input gpib_status_pkg::cmd_t c);
		logic [4:0] o;
		logic [1:0] k;
		int         g;
		o = grp_offset(c);
		k = o[1:0];
		g = int'(o[4:2]);
		if (is_grp_cmd(c)) begin
			case (k)
				`KIND_COND:  return cond_sync_reg[g] & grp_keep;
				`KIND_EVENT: return event_reg[g];
				default:     return enable_reg[g];
			endcase
		end
		case (c)
			gpib_status_pkg::std_enable_query:  return {8'h00, ese_reg};
			gpib_status_pkg::std_event_query:   return {8'h00, std_event_reg};
			gpib_status_pkg::srq_enable_query:  return {8'h00, sre_reg};
			gpib_status_pkg::status_byte_query: return {8'h00, stb_query};
			default:                            return 16'h0000;
		endcase
	endfunction

	// Procedural so a change in any register the mux reads re-evaluates it
	always_comb begin
		rd_value = read_mux(cmd);
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	// Reset acts even with ce_in low so power-on always zeroes the masks
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			cond_meta_reg   <= '0;
			cond_sync_reg   <= '0;
			cond_prev_reg   <= '0;
			event_reg       <= '0;
			enable_reg      <= {3{`GRP_MASK_RST}};
			std_event_reg   <= `BYTE_RST;
			ese_reg         <= `BYTE_RST;
			sre_reg         <= `BYTE_RST;
			reason_prev_reg <= `BYTE_RST;
			rqs_reg         <= 1'b0;
		end else if (ce_in) begin
			cond_meta_reg   <= cond_raw;
			cond_sync_reg   <= cond_meta_reg;
			cond_prev_reg   <= cond_sync_reg;
			event_reg       <= event_next;
			enable_reg      <= enable_next;
			std_event_reg   <= std_event_next;
			ese_reg         <= ese_next;
			sre_reg         <= sre_next;
			reason_prev_reg <= reason;
			rqs_reg         <= rqs_next;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			resp_valid_reg <= 1'b0;
			resp_reg       <= '0;
			poll_valid_reg <= 1'b0;
			poll_byte_reg  <= `BYTE_RST;
			stb_reg        <= `BYTE_RST;
			flush_reg      <= 1'b0;
		end else if (ce_in) begin
			resp_valid_reg <= cmd_hit && is_query(cmd);
			resp_reg       <= cmd_hit ? {rd_value, to_bcd(rd_value)} : resp_reg;
			poll_valid_reg <= poll_hit;
			poll_byte_reg  <= poll_hit ? (stb_base | ({7'h00, rqs_reg} << `STB_MSS_BIT)) : poll_byte_reg;
			stb_reg        <= stb_query;
			flush_reg      <= cls_hit;
		end
	end

	assign resp_valid_out      = resp_valid_reg;
	assign resp_out            = resp_reg;
	assign poll_valid_out      = poll_valid_reg;
	assign poll_byte_out       = poll_byte_reg;
	assign srq_out             = rqs_reg;
	assign status_byte_out     = stb_reg;
	assign err_queue_flush_out = flush_reg;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_query(gpib_status_pkg::cmd_t c);
		ce_in && cmd_valid_in && cmd_in.cmd == c;
	endsequence

	sequence s_answer(logic [15:0] v);
		resp_valid_out && resp_out.value == v;
	endsequence

	a_sre_bit_six: assert property (sre_reg[`STB_MSS_BIT] == 1'b0)
		else $error("service request mask bit 6 is set");
	a_erb_summary: assert property (ce_in |=> status_byte_out[`STB_ERB_BIT] == $past(err_queue_nonempty_in))
		else $error("error queue summary does not follow the queue");
	a_mav_summary: assert property (ce_in |=> status_byte_out[`STB_MAV_BIT] == $past(out_queue_nonempty_in))
		else $error("message available does not follow the output queue");
	a_hsb_summary: assert property (ce_in |=> status_byte_out[`STB_HSB_BIT] == $past(grp_summary[`GRP_HW]))
		else $error("hardware summary bit wrong");
	a_csb_summary: assert property (ce_in |=>
	                                status_byte_out[`STB_CSB_BIT] == $past(grp_summary[`GRP_CP]))
		else $error("coupling summary bit wrong");
	a_isb_summary: assert property (ce_in |=>
	                                status_byte_out[`STB_ISB_BIT] == $past(grp_summary[`GRP_IN]))
		else $error("instrument summary bit wrong");
	a_srq_on_reason: assert property (ce_in && new_reason |=> srq_out)
		else $error("new reason did not raise SRQ");
	a_rqs_cause: assert property ($rose(srq_out) |-> $past(new_reason) && $past(ce_in))
		else $error("request for service set without a new reason");
	a_rqs_clear: assert property (ce_in && !new_reason && (!mss || serial_poll_in) |=> !srq_out)
		else $error("request for service not cleared");
	a_cls_clear: assert property (ce_in && cls_hit && std_event_set_in == 8'h00
	                              |=> std_event_reg == 8'h00 && err_queue_flush_out)
		else $error("clear status left events or queue");
	a_ese_readback: assert property (s_query(gpib_status_pkg::std_enable_query)
	                                 |=> s_answer({8'h00, $past(ese_reg)}))
		else $error("standard enable readback wrong");
	a_mss_bit: assert property (s_query(gpib_status_pkg::status_byte_query)
	                            |=> resp_valid_out && resp_out.value[`STB_MSS_BIT] == $past(mss))
		else $error("status byte query lacks master summary");
	a_event_latch: assert property (ce_in && !g_grp[0].clr
	                                |=> (event_reg[0] & $past(event_reg[0])) == $past(event_reg[0]))
		else $error("latched event bit lost");
	a_mask_keep: assert property (ce_in && cls_hit |=> enable_reg == $past(enable_reg))
		else $error("clear status changed an enable mask");
	a_bcd_digits: assert property (resp_valid_out |-> resp_out.bcd == {
	                               4'(resp_out.value / 16'h2710),
	                               4'(resp_out.value / 16'h03E8 % 16'h000A),
	                               4'(resp_out.value / 16'h0064 % 16'h000A),
	                               4'(resp_out.value / 16'h000A % 16'h000A),
	                               4'(resp_out.value % 16'h000A)})
		else $error("decimal answer does not match value");
	a_poll_rqs: assert property (ce_in && serial_poll_in |=>
	                             poll_valid_out && poll_byte_out[`STB_MSS_BIT] == $past(srq_out))
		else $error("serial poll byte lacks request for service");
	a_cond_read: assert property (s_query(gpib_status_pkg::hardware_condition_query)
	                              |=> s_answer($past(cond_sync_reg[0]) & grp_keep))
		else $error("condition query does not return the live condition");

endmodule

`default_nettype wire

// >>> shared/gpib_status_defines.svh
// Constants for the GPIB status reporting block: bit positions and reset values.
// Assumes inclusion by bare name from the design files only.
`ifndef GPIB_STATUS_DEFINES_SVH
`define GPIB_STATUS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------------------
`define STB_UNUSED_BIT 0
`define STB_ISB_BIT    1
`define STB_CSB_BIT    2
`define STB_HSB_BIT    3
`define STB_MAV_BIT    4
`define STB_ESB_BIT    5
`define STB_MSS_BIT    6
`define STB_ERB_BIT    7

// ----------------------------------------------------------------------------
// Group indices and reset values
// ----------------------------------------------------------------------------
`define GRP_HW         0
`define GRP_CP         1
`define GRP_IN         2
`define KIND_COND      2'h0
`define KIND_EN_WR     2'h1
`define KIND_EN_RD     2'h2
`define KIND_EVENT     2'h3
`define GRP_MASK_RST   16'h0000
`define BYTE_RST       8'h00
`define SRE_WR_MASK    8'hBF

`endif

// >>> shared/gpib_status_pkg.sv
// Types shared by the GPIB status reporting block.
// Assumes a command parser upstream that turns bus messages into these codes.
`default_nettype none

package gpib_status_pkg;

	// ------------------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------------------
	typedef enum logic [4:0] {
		no_command                 = 5'h00,
		clear_status               = 5'h01,
		std_enable_write           = 5'h02,
		std_enable_query           = 5'h03,
		std_event_query            = 5'h04,
		srq_enable_write           = 5'h05,
		srq_enable_query           = 5'h06,
		status_byte_query          = 5'h07,
		hardware_condition_query   = 5'h08,
		hardware_enable_write      = 5'h09,
		hardware_enable_query      = 5'h0A,
		hardware_event_query       = 5'h0B,
		coupling_condition_query   = 5'h0C,
		coupling_enable_write      = 5'h0D,
		coupling_enable_query      = 5'h0E,
		coupling_event_query       = 5'h0F,
		instrument_condition_query = 5'h10,
		instrument_enable_write    = 5'h11,
		instrument_enable_query    = 5'h12,
		instrument_event_query     = 5'h13
	} cmd_t;

	// ------------------------------------------------------------------------
	// Request and answer carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		cmd_t        cmd;
		logic [15:0] data;
	} cmd_req_t;

	typedef struct packed {
		logic [15:0] value;
		logic [19:0] bcd;
	} resp_t;

endpackage

`default_nettype wire

// >>> verif/gpib_ctrl_model.sv
// Bus controller model: issues parsed commands and serial polls to the status block.
// Assumes the block takes a request on every rising edge with ce high and valid high.
`timescale 1ns/1ps
`default_nettype none

module gpib_ctrl_model (
	// Clock
	input  wire logic                   ref_clk_in,
	// Requests toward the block
	output logic                        cmd_valid_out,
	output gpib_status_pkg::cmd_req_t   cmd_out,
	output logic                        serial_poll_out,
	// Answers from the block
	input  wire logic                   resp_valid_in,
	input  wire gpib_status_pkg::resp_t resp_in,
	input  wire logic                   poll_valid_in,
	input  wire logic [7:0]             poll_byte_in
);
	initial begin
		cmd_valid_out   = 1'b0;
		cmd_out         = '0;
		serial_poll_out = 1'b0;
	end

	// ------------------------------------------------------------------------
	// Requests
	// ------------------------------------------------------------------------
	// Write data is already decimal program data turned into binary upstream
	task automatic send(input gpib_status_pkg::cmd_t c, input logic [15:0] d);
		@(posedge ref_clk_in);
		cmd_valid_out <= 1'b1;
		cmd_out       <= '{cmd: c, data: d};
		@(posedge ref_clk_in);
		// Released data shows the inverse so a stale value never looks live
		cmd_valid_out <= 1'b0;
		cmd_out.data  <= ~d;
	endtask

	task automatic ask(input gpib_status_pkg::cmd_t c, output gpib_status_pkg::resp_t r,
			output logic ok);
		send(c, 16'h0000);
		ok = 1'b0;
		r  = '0;
		for (int i = 0; i < 3 && !ok; i++) begin
			#1;
			if (resp_valid_in === 1'b1) begin
				ok = 1'b1;
				r  = resp_in;
			end else begin
				@(posedge ref_clk_in);
			end
		end
	endtask

	task automatic poll(output logic [7:0] b, output logic ok);
		@(posedge ref_clk_in);
		serial_poll_out <= 1'b1;
		@(posedge ref_clk_in);
		serial_poll_out <= 1'b0;
		#1;
		ok = (poll_valid_in === 1'b1);
		b  = poll_byte_in;
	endtask
endmodule

`default_nettype wire

// >>> verif/test_gpib_status_core.sv
// Self-checking bench for the status reporting block.
// Assumes the controller model drives the command port; bench drives pins.
`timescale 1ns/1ps
`default_nettype none

`define check_eq(nm, exp, got) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
	$display("unexpected %s expected %0h seen %0h", nm, exp, got); end end

module test_gpib_status_core;
	logic                      ref_clk_in;
	logic                      rstn_in;
	logic                      ce_in;
	logic [15:0]               cond [3];
	logic [7:0]                std_set;
	logic                      err_q;
	logic                      out_q;
	logic                      cmd_valid;
	gpib_status_pkg::cmd_req_t cmd_req;
	logic                      serial_poll;
	logic                      resp_valid;
	gpib_status_pkg::resp_t    resp;
	logic                      poll_valid;
	logic [7:0]                poll_byte;
	logic                      srq_out;
	logic [7:0]                status_byte_out;
	logic                      err_queue_flush_out;
	int                        error_cnt = 0;
	int                        compares  = 0;
	int                        flush_cnt = 0;
	int                        f0;
	gpib_status_pkg::cmd_t     wr_c [3];
	gpib_status_pkg::cmd_t     en_c [3];
	gpib_status_pkg::cmd_t     cd_c [3];
	gpib_status_pkg::cmd_t     ev_c [3];
	logic [7:0]                sb_mask [3] = '{8'h08, 8'h04, 8'h02};

	gpib_status_core u_dut (
		.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
		.hw_cond_in(cond[0]), .cpl_cond_in(cond[1]), .ins_cond_in(cond[2]),
		.std_event_set_in(std_set), .err_queue_nonempty_in(err_q),
		.out_queue_nonempty_in(out_q), .cmd_valid_in(cmd_valid), .cmd_in(cmd_req),
		.serial_poll_in(serial_poll), .resp_valid_out(resp_valid), .resp_out(resp),
		.poll_valid_out(poll_valid), .poll_byte_out(poll_byte), .srq_out(srq_out),
		.status_byte_out(status_byte_out), .err_queue_flush_out(err_queue_flush_out)
	);

	gpib_ctrl_model u_ctrl (
		.ref_clk_in(ref_clk_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd_req),
		.serial_poll_out(serial_poll), .resp_valid_in(resp_valid), .resp_in(resp),
		.poll_valid_in(poll_valid), .poll_byte_in(poll_byte)
	);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end

	always @(posedge ref_clk_in) begin
		if (err_queue_flush_out === 1'b1) begin
			flush_cnt <= flush_cnt + 1;
		end
	end

	function automatic logic [19:0] to_bcd(input logic [15:0] v);
		logic [19:0] b;
		int          x;
		b = '0;
		x = v;
		for (int i = 0; i < 5; i++) begin
			b[i*4 +: 4] = 4'(x % 10);
			x = x / 10;
		end
		return b;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	task automatic q_chk(input gpib_status_pkg::cmd_t c, input logic [15:0] exp);
		gpib_status_pkg::resp_t r;
		logic                   ok;
		u_ctrl.ask(c, r, ok);
		`check_eq("answer present", 1'b1, ok)
		`check_eq("answer value", exp, r.value)
		`check_eq("answer digits", to_bcd(exp), r.bcd)
	endtask

	task automatic p_chk(input logic [7:0] exp);
		logic [7:0] b;
		logic       ok;
		u_ctrl.poll(b, ok);
		`check_eq("poll present", 1'b1, ok)
		`check_eq("poll byte", exp, b)
	endtask

	task automatic wrap_up();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk_in);
		error_cnt++;
		wrap_up();
	end

	// ------------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------------
	initial begin
		wr_c = '{gpib_status_pkg::hardware_enable_write, gpib_status_pkg::coupling_enable_write,
			gpib_status_pkg::instrument_enable_write};
		en_c = '{gpib_status_pkg::hardware_enable_query, gpib_status_pkg::coupling_enable_query,
			gpib_status_pkg::instrument_enable_query};
		cd_c = '{gpib_status_pkg::hardware_condition_query,
			gpib_status_pkg::coupling_condition_query,
			gpib_status_pkg::instrument_condition_query};
		ev_c = '{gpib_status_pkg::hardware_event_query, gpib_status_pkg::coupling_event_query,
			gpib_status_pkg::instrument_event_query};
		rstn_in = 1'b0;
		ce_in   = 1'b1;
		cond    = '{16'h0000, 16'h0000, 16'h0000};
		std_set = 8'h00;
		err_q   = 1'b0;
		out_q   = 1'b0;
		repeat (6) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		cyc(2);
		`check_eq("status byte", 8'h00, status_byte_out)
		q_chk(gpib_status_pkg::std_enable_query, 16'h0000);
		q_chk(gpib_status_pkg::srq_enable_query, 16'h0000);
		for (int g = 0; g < 3; g++) begin
			q_chk(en_c[g], 16'h0000);
			u_ctrl.send(wr_c[g], 16'h8005);
			q_chk(en_c[g], 16'h8005);
			@(posedge ref_clk_in);
			cond[g] <= 16'h0005;
			cyc(6);
			`check_eq("group summary", sb_mask[g], status_byte_out)
			q_chk(cd_c[g], 16'h0005);
			q_chk(ev_c[g], 16'h0005);
			cyc(2);
			`check_eq("summary after read", 8'h00, status_byte_out)
			q_chk(ev_c[g], 16'h0000);
			@(posedge ref_clk_in);
			cond[g] <= 16'h0000;
			cyc(6);
			q_chk(cd_c[g], 16'h0000);
		end
		// Standard events, then clear-status
		u_ctrl.send(gpib_status_pkg::std_enable_write, 16'h0021);
		q_chk(gpib_status_pkg::std_enable_query, 16'h0021);
		@(posedge ref_clk_in);
		std_set <= 8'h21;
		@(posedge ref_clk_in);
		std_set <= 8'h00;
		cyc(3);
		`check_eq("event summary", 8'h20, status_byte_out)
		q_chk(gpib_status_pkg::std_event_query, 16'h0021);
		q_chk(gpib_status_pkg::std_event_query, 16'h0000);
		@(posedge ref_clk_in);
		std_set  <= 8'h01;
		cond[0] <= 16'h0001;
		@(posedge ref_clk_in);
		std_set <= 8'h00;
		cyc(6);
		f0 = flush_cnt;
		u_ctrl.send(gpib_status_pkg::clear_status, 16'h0000);
		cyc(3);
		`check_eq("flush pulses", 1, flush_cnt - f0)
		q_chk(gpib_status_pkg::std_event_query, 16'h0000);
		q_chk(gpib_status_pkg::hardware_event_query, 16'h0000);
		q_chk(gpib_status_pkg::std_enable_query, 16'h0021);
		q_chk(gpib_status_pkg::hardware_enable_query, 16'h8005);
		// Service request mask and request-for-service
		u_ctrl.send(gpib_status_pkg::srq_enable_write, 16'h0040);
		q_chk(gpib_status_pkg::srq_enable_query, 16'h0000);
		u_ctrl.send(gpib_status_pkg::srq_enable_write, 16'h00FF);
		q_chk(gpib_status_pkg::srq_enable_query, 16'h00BF);
		u_ctrl.send(gpib_status_pkg::srq_enable_write, 16'h0080);
		@(posedge ref_clk_in);
		out_q <= 1'b1;
		cyc(3);
		`check_eq("message available", 8'h10, status_byte_out)
		`check_eq("srq idle", 1'b0, srq_out)
		@(posedge ref_clk_in);
		err_q <= 1'b1;
		cyc(3);
		`check_eq("error summary", 8'hD0, status_byte_out)
		`check_eq("srq raised", 1'b1, srq_out)
		q_chk(gpib_status_pkg::status_byte_query, 16'h00D0);
		p_chk(8'hD0);
		`check_eq("srq after poll", 1'b0, srq_out)
		cyc(4);
		`check_eq("srq no new reason", 1'b0, srq_out)
		@(posedge ref_clk_in);
		err_q <= 1'b0;
		cyc(3);
		`check_eq("error summary off", 8'h10, status_byte_out)
		@(posedge ref_clk_in);
		err_q <= 1'b1;
		cyc(3);
		`check_eq("srq new reason", 1'b1, srq_out)
		@(posedge ref_clk_in);
		err_q <= 1'b0;
		cyc(3);
		`check_eq("srq summary false", 1'b0, srq_out)
		u_ctrl.send(gpib_status_pkg::srq_enable_write, 16'h0000);
		@(posedge ref_clk_in);
		err_q <= 1'b1;
		cyc(3);
		`check_eq("srq masked", 1'b0, srq_out)
		// A frozen clock enable must drop the write
		ce_in <= 1'b0;
		u_ctrl.send(gpib_status_pkg::srq_enable_write, 16'h0004);
		ce_in <= 1'b1;
		q_chk(gpib_status_pkg::srq_enable_query, 16'h0000);
		u_ctrl.send(gpib_status_pkg::srq_enable_write, 16'h0080);
		cyc(3);
		`check_eq("srq mask change", 1'b1, srq_out)
		q_chk(gpib_status_pkg::srq_enable_query, 16'h0080);
		wrap_up();
	end
endmodule

`undef check_eq
`default_nettype wire
